// >>> pmd_pkg.sv
// shared constants, state codes and carrier structs for the phy data port
package pmd_pkg;

  // core clock and the clock periods the port must present, in ns
  localparam int unsigned CLOCK_PERIOD_NS = 50;
  localparam int unsigned MII_PERIOD_10_NS = 400;
  localparam int unsigned MII_PERIOD_100_NS = 40;
  localparam int unsigned REF_PERIOD_NS = 20;

  // half periods in core cycles; rounded down, never below one cycle
  localparam int unsigned HALF_10_INT = (MII_PERIOD_10_NS / (2 * CLOCK_PERIOD_NS) > 0) ?
    MII_PERIOD_10_NS / (2 * CLOCK_PERIOD_NS) : 1;
  localparam int unsigned HALF_100_INT = (MII_PERIOD_100_NS / (2 * CLOCK_PERIOD_NS) > 0) ?
    MII_PERIOD_100_NS / (2 * CLOCK_PERIOD_NS) : 1;
  localparam int unsigned HALF_REF_INT = (REF_PERIOD_NS / (2 * CLOCK_PERIOD_NS) > 0) ?
    REF_PERIOD_NS / (2 * CLOCK_PERIOD_NS) : 1;
  localparam int unsigned HALF_WIDTH = 8;
  localparam logic [HALF_WIDTH-1:0] HALF_10 = HALF_WIDTH'(HALF_10_INT);
  localparam logic [HALF_WIDTH-1:0] HALF_100 = HALF_WIDTH'(HALF_100_INT);
  localparam logic [HALF_WIDTH-1:0] HALF_REF = HALF_WIDTH'(HALF_REF_INT);

  // mode strap codes and reduced-interface pacing
  localparam logic [2:0] STRAP_MII = 3'h0;
  localparam logic [2:0] STRAP_RMII = 3'h1;
  localparam logic [3:0] RMII_10M_REPEAT = 4'ha;
  localparam logic [3:0] IDLE_NIBBLE = 4'h0;
  localparam logic [1:0] IDLE_DIBIT = 2'h0;

  // receive framer states
  typedef enum logic [1:0] {
    PMD_RX_IDLE = 2'b00,
    PMD_RX_PREAMBLE = 2'b01,
    PMD_RX_DATA = 2'b10
  } pmd_rx_state_t;

  // interface mode held from the last reset
  typedef struct packed {
    logic rmii;
    logic [2:0] code;
  } pmd_mode_t;

  // events and nibbles delivered by the line decoder
  typedef struct packed {
    logic strobe;      // one decoded nibble this cycle
    logic [3:0] nibble;
    logic carrier;     // line energy present
    logic squelch;     // 10 Mbps squelch passed, valid preamble seen
    logic sfd;         // first nibble of the start-of-frame delimiter
    logic eof;         // 10 Mbps end-of-frame marker
    logic startPair;   // 100 Mbps start-of-stream pair
    logic endPair;     // 100 Mbps end-of-stream pair
    logic idleSym;     // 100 Mbps idle symbols
    logic twoZeros;    // 100 Mbps two non-adjacent zeros within ten bits
    logic codeErr;     // symbol or coding error
  } pmd_line_rx_t;

  // nibbles handed to the line encoder
  typedef struct packed {
    logic strobe;
    logic active;
    logic [3:0] nibble;
  } pmd_line_tx_t;

endpackage

// >>> pmd_clk_gen.sv
// divider that makes an interface clock level and its rising-edge strobe
`timescale 1ns/100ps
module pmd_clk_gen #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] halfCount,
  output logic level,
  output logic rise
);

  // refuse a counter too narrow to hold any half period
  if (WIDTH < 1) begin : g_bad_width
    $error("pmd_clk_gen: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic level;
  } pmd_clk_state_t;

  pmd_clk_state_t st;
  pmd_clk_state_t next_st;
  logic wrap;

  // a half count of zero is treated as one so the clock never stalls
  assign wrap = (st.count + WIDTH'(1) >= halfCount);
  assign level = st.level;
  assign rise = wrap && !st.level;

  // count one half period, then toggle
  always_comb begin
    next_st = st;
    next_st.count = wrap ? '0 : st.count + WIDTH'(1);
    if (wrap) next_st.level = !st.level;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end

endmodule // pmd_clk_gen

// >>> pmd_mode_strap.sv
// catches the mode straps during reset and holds them while running
`timescale 1ns/100ps
module pmd_mode_strap (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] strap,
  output pmd_pkg::pmd_mode_t mode
);

  pmd_pkg::pmd_mode_t st;
  pmd_pkg::pmd_mode_t next_st;

  assign mode = st;

  // straps are only looked at while reset is held; later changes are ignored
  always_comb begin
    next_st = st;
    if (!rst_n) begin
      next_st.code = strap;
      next_st.rmii = (strap == pmd_pkg::STRAP_RMII);
    end
  end

  // the reset is synchronous, so the capture is an ordinary clocked load
  always_ff @(posedge clock) begin
    st <= next_st;
  end

endmodule // pmd_mode_strap

// >>> pmd_phy_data_port.sv
// phy-side mii / rmii data port between the line codec and the mac
`timescale 1ns/100ps
module pmd_phy_data_port (
  input wire logic clock,
  input wire logic rst_n,
  // straps and operating mode
  input wire logic [2:0] modeStrap,
  input wire logic clockMode50,
  input wire logic speed100,
  input wire logic fullDuplex,
  input wire logic linkUp,
  // line codec side
  input pmd_pkg::pmd_line_rx_t lineRx,
  output pmd_pkg::pmd_line_tx_t lineTx,
  // mii pins
  output logic txClockOut,
  input wire logic txEnable,
  input wire logic [3:0] txData,
  output logic rxClockOut,
  output logic rxClockRecovered,
  output logic rxValid,
  output logic [3:0] rxData,
  output logic rxError,
  output logic carrierSense,
  output logic collision,
  // rmii pins
  output logic refClockOut,
  output logic refClockOutEnable,
  input wire logic rmiiTxEnable,
  input wire logic [1:0] rmiiTxData,
  output logic crsDv,
  output logic [1:0] rmiiRxData,
  output logic rmiiRxError
);

  typedef struct packed {
    pmd_pkg::pmd_rx_state_t rxState;
    logic carrier;
    logic [3:0] holdNibble;
    logic holdFull;
    logic errPending;
    // mii receive pins
    logic rxValid;
    logic [3:0] rxData;
    logic rxError;
    // line transmit
    pmd_pkg::pmd_line_tx_t lineTx;
    // rmii transmit pairing
    logic [1:0] txLowDibit;
    logic txHalf;
    logic [3:0] txRepeat;
    // rmii receive splitting
    logic crsDv;
    logic [1:0] rmiiRxData;
    logic rmiiRxError;
    logic [1:0] rxHighDibit;
    logic rxHalf;
    logic [3:0] rxRepeat;
  } pmd_port_state_t;

  pmd_port_state_t st;
  pmd_port_state_t next_st;
  pmd_pkg::pmd_mode_t mode;
  logic [pmd_pkg::HALF_WIDTH-1:0] miiHalf;
  logic txLevel;
  logic txEdge;
  logic rxLevel;
  logic rxEdge;
  logic refLevel;
  logic refEdge;
  logic popEdge;
  logic rmiiSlot;
  logic rmiiTxSlot;
  logic detect;

  // repeat reload for the reduced interface; zero means every edge
  function automatic logic [3:0] pace(input logic fast);
    pace = fast ? 4'h0 : pmd_pkg::RMII_10M_REPEAT - 4'h1;
  endfunction

  // straps caught at reset only
  pmd_mode_strap u_strap (
    .clock(clock),
    .rst_n(rst_n),
    .strap(modeStrap),
    .mode(mode)
  );

  // mii clocks follow the link speed
  assign miiHalf = speed100 ? pmd_pkg::HALF_100 : pmd_pkg::HALF_10;

  pmd_clk_gen #(.WIDTH(pmd_pkg::HALF_WIDTH)) u_tx_clk (
    .clock(clock),
    .rst_n(rst_n),
    .halfCount(miiHalf),
    .level(txLevel),
    .rise(txEdge)
  );

  pmd_clk_gen #(.WIDTH(pmd_pkg::HALF_WIDTH)) u_rx_clk (
    .clock(clock),
    .rst_n(rst_n),
    .halfCount(miiHalf),
    .level(rxLevel),
    .rise(rxEdge)
  );

  // one reference runs both rmii directions, whatever the clock mode
  pmd_clk_gen #(.WIDTH(pmd_pkg::HALF_WIDTH)) u_ref_clk (
    .clock(clock),
    .rst_n(rst_n),
    .halfCount(pmd_pkg::HALF_REF),
    .level(refLevel),
    .rise(refEdge)
  );

  // clock pins; in mii mode the transmit clock never stops, even between frames; both mii clocks are held low in rmii mode
  assign txClockOut = !mode.rmii && txLevel;
  assign rxClockOut = !mode.rmii && rxLevel;
  // source of the receive clock: 1 = recovered from the line
  assign rxClockRecovered = speed100 ? linkUp : (linkUp && st.carrier);
  // reference out only in 25 MHz mode; left undriven in 50 MHz mode
  assign refClockOutEnable = mode.rmii && !clockMode50;
  assign refClockOut = refClockOutEnable && refLevel;

  // collision is plain logic so it needs neither interface clock
  assign collision = !mode.rmii && !fullDuplex && st.lineTx.active && st.carrier;

  // rmii slots: a paced reference edge, with one pacing count for receive and one for transmit
  assign rmiiSlot = refEdge && (st.rxRepeat == 4'h0);
  assign rmiiTxSlot = refEdge && (st.txRepeat == 4'h0);
  // an rmii slot busy with the high dibit must not empty the hold, or a fresh nibble is lost
  assign popEdge = mode.rmii ? (rmiiSlot && !st.rxHalf) : rxEdge;
  // rmii carrier detect per speed
  assign detect = speed100 ? lineRx.twoZeros : lineRx.squelch;

  assign lineTx = st.lineTx;
  assign rxValid = st.rxValid;
  assign rxData = st.rxData;
  assign rxError = st.rxError;
  assign carrierSense = st.carrier;
  assign crsDv = st.crsDv;
  assign rmiiRxData = st.rmiiRxData;
  assign rmiiRxError = st.rmiiRxError;

  always_comb begin
    next_st = st;
    next_st.lineTx.strobe = 1'b0;

    // ---------------- transmit ----------------
    if (!mode.rmii) begin
      // nibbles are only taken with enable high; idle data is dropped
      if (txEdge) begin
        if (txEnable) begin
          next_st.lineTx.strobe = 1'b1;
          next_st.lineTx.nibble = txData;
          next_st.lineTx.active = 1'b1;
        end else begin
          next_st.lineTx.active = 1'b0;
        end
      end
    end else if (refEdge) begin
      // dibits pair low first; at 10M each dibit is sampled once per ten edges
      if (rmiiTxEnable) begin
        next_st.txRepeat = (st.txRepeat == 4'h0) ? pace(speed100) : st.txRepeat - 4'h1;
        if (rmiiTxSlot) begin
          next_st.lineTx.active = 1'b1;
          if (!st.txHalf) begin
            next_st.txLowDibit = rmiiTxData;
            next_st.txHalf = 1'b1;
          end else begin
            next_st.lineTx.strobe = 1'b1;
            next_st.lineTx.nibble = {rmiiTxData, st.txLowDibit};
            next_st.txHalf = 1'b0;
          end
        end
      end else begin
        // an odd dibit left at frame end is dropped
        next_st.txRepeat = 4'h0;
        next_st.txHalf = 1'b0;
        next_st.lineTx.active = 1'b0;
      end
    end

    // ---------------- receive framer ----------------
    // output side first, so a nibble arriving this cycle is not overwritten
    if (popEdge) begin
      if (st.holdFull) next_st.holdFull = 1'b0;
    end
    unique case (st.rxState)
      pmd_pkg::PMD_RX_IDLE: begin
        if (speed100 && lineRx.startPair) begin
          next_st.carrier = 1'b1;
          next_st.rxState = pmd_pkg::PMD_RX_DATA;
        end else if (!speed100 && lineRx.squelch) begin
          next_st.carrier = 1'b1;
          next_st.rxState = pmd_pkg::PMD_RX_PREAMBLE;
        end
      end
      pmd_pkg::PMD_RX_PREAMBLE: begin
        // 10M preamble is withheld; delivery starts with the delimiter
        if (lineRx.eof || !lineRx.carrier) begin
          next_st.carrier = 1'b0;
          next_st.rxState = pmd_pkg::PMD_RX_IDLE;
        end else if (lineRx.strobe && lineRx.sfd) begin
          next_st.holdNibble = lineRx.nibble;
          next_st.holdFull = 1'b1;
          next_st.rxState = pmd_pkg::PMD_RX_DATA;
        end
      end
      pmd_pkg::PMD_RX_DATA: begin
        if (lineRx.strobe) begin
          next_st.holdNibble = lineRx.nibble;
          next_st.holdFull = 1'b1;
        end
        // an error latched now survives a pop in the same cycle
        if (lineRx.codeErr) next_st.errPending = 1'b1;
        if (speed100 ? (lineRx.endPair || lineRx.idleSym) : lineRx.eof) begin
          next_st.carrier = 1'b0;
          next_st.rxState = pmd_pkg::PMD_RX_IDLE;
        end
      end
      default: begin
        next_st.carrier = 1'b0;
        next_st.rxState = pmd_pkg::PMD_RX_IDLE;
      end
    endcase

    // ---------------- mii receive pins ----------------
    if (!mode.rmii && rxEdge) begin
      if (st.holdFull) begin
        next_st.rxValid = 1'b1;
        next_st.rxData = st.holdNibble;
        next_st.rxError = st.errPending;
        next_st.errPending = lineRx.codeErr && (st.rxState == pmd_pkg::PMD_RX_DATA);
      end else if (st.rxState != pmd_pkg::PMD_RX_DATA) begin
        // frame over and nothing left: drop valid, show idle
        next_st.rxValid = 1'b0;
        next_st.rxData = pmd_pkg::IDLE_NIBBLE;
        next_st.rxError = 1'b0;
      end else begin
        next_st.rxError = 1'b0;
      end
    end

    // ---------------- rmii receive pins ----------------
    if (mode.rmii) begin
      // carrier/valid rises as soon as the detector fires
      if (!st.crsDv && detect) next_st.crsDv = 1'b1;
      if (refEdge) begin
        next_st.rxRepeat = (st.rxRepeat == 4'h0) ? pace(speed100) : st.rxRepeat - 4'h1;
        if (rmiiSlot) begin
          if (st.rxHalf) begin
            next_st.rmiiRxData = st.rxHighDibit;
            next_st.rxHalf = 1'b0;
          end else if (st.holdFull) begin
            next_st.rmiiRxData = st.holdNibble[1:0];
            next_st.rxHighDibit = st.holdNibble[3:2];
            next_st.rxHalf = 1'b1;
            next_st.crsDv = 1'b1;
            next_st.rmiiRxError = st.errPending;
            next_st.errPending = lineRx.codeErr && (st.rxState == pmd_pkg::PMD_RX_DATA);
          end else begin
            // nothing decoded yet, or the frame has drained
            next_st.rmiiRxData = pmd_pkg::IDLE_DIBIT;
            next_st.rmiiRxError = 1'b0;
            if (!lineRx.carrier && st.rxState != pmd_pkg::PMD_RX_DATA) begin
              next_st.crsDv = detect;
              next_st.rxRepeat = 4'h0;
            end
          end
        end
      end
    end
  end

  // one register for all state; synchronous reset to idle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
      st.rxState <= pmd_pkg::PMD_RX_IDLE;
    end else begin
      st <= next_st;
    end
  end

endmodule // pmd_phy_data_port

// >>> pmd_phy_data_port_assertions.sv
// concurrent checks on the pins of the phy data port
`timescale 1ns/100ps
module pmd_port_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] modeStrap,
  input wire logic clockMode50,
  input wire logic speed100,
  input wire logic fullDuplex,
  input wire logic linkUp,
  input pmd_pkg::pmd_line_rx_t lineRx,
  input pmd_pkg::pmd_line_tx_t lineTx,
  input wire logic txClockOut,
  input wire logic txEnable,
  input wire logic [3:0] txData,
  input wire logic rxClockOut,
  input wire logic rxClockRecovered,
  input wire logic rxValid,
  input wire logic carrierSense,
  input wire logic collision,
  input wire logic refClockOut,
  input wire logic refClockOutEnable,
  input wire logic crsDv,
  input wire logic [1:0] rmiiRxData
);
  // own copy of the strap, taken only in reset, so a late strap move is caught
  logic isRmii;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      isRmii <= (modeStrap == pmd_pkg::STRAP_RMII);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // slow transmit clock stays high four core cycles per half period
  sequence slowHigh;
    txClockOut [*4];
  endsequence
  tx_take_a: assert property ($rose(txClockOut) |-> lineTx.strobe == $past(txEnable) &&
    (!$past(txEnable) || lineTx.nibble == $past(txData))) else $error("mii nibble mistaken");
  tx_slow_a: assert property ($rose(txClockOut) && !speed100 |-> slowHigh ##1 !txClockOut)
    else $error("slow tx clock period wrong");
  tx_fast_a: assert property ($rose(txClockOut) && speed100 |=> !txClockOut)
    else $error("fast tx clock period wrong");
  rx_phase_a: assert property (rxClockOut == txClockOut) else $error("rx clock off");
  rx_source_a: assert property (rxClockRecovered == (linkUp && (speed100 || carrierSense)))
    else $error("rx clock source wrong");
  rx_sync_a: assert property ($changed(rxValid) |-> $rose(rxClockOut))
    else $error("rx valid moved off clock");
  col_rule_a: assert property (collision == (!isRmii && !fullDuplex && lineTx.active &&
    carrierSense)) else $error("collision wrong");
  crs_slow_a: assert property (!isRmii && !speed100 && lineRx.squelch |=> carrierSense)
    else $error("carrier missed squelch");
  crs_start_a: assert property (!isRmii && speed100 && lineRx.startPair |=> carrierSense)
    else $error("carrier missed start pair");
  crs_end_a: assert property (!isRmii && speed100 && lineRx.endPair && !lineRx.startPair
    |=> !carrierSense) else $error("carrier missed end pair");
  ref_enable_a: assert property (refClockOutEnable == (isRmii && !clockMode50))
    else $error("ref enable wrong");
  ref_quiet_a: assert property (!refClockOutEnable |-> !refClockOut)
    else $error("ref clock driven while unused");
  dv_rise_a: assert property (isRmii && speed100 && lineRx.twoZeros && lineRx.carrier
    |=> crsDv) else $error("crs_dv missed detect");
  dv_idle_a: assert property (!crsDv |-> rmiiRxData == 2'h0)
    else $error("rx dibit not idle");
endmodule // pmd_port_chk
bind pmd_phy_data_port pmd_port_chk i_pmd_port_chk (
  .clock(clock), .rst_n(rst_n), .modeStrap(modeStrap), .clockMode50(clockMode50),
  .speed100(speed100), .fullDuplex(fullDuplex), .linkUp(linkUp), .lineRx(lineRx),
  .lineTx(lineTx), .txClockOut(txClockOut), .txEnable(txEnable), .txData(txData),
  .rxClockOut(rxClockOut), .rxClockRecovered(rxClockRecovered), .rxValid(rxValid),
  .carrierSense(carrierSense), .collision(collision), .refClockOut(refClockOut),
  .refClockOutEnable(refClockOutEnable), .crsDv(crsDv), .rmiiRxData(rmiiRxData)
);

// >>> pmd_mac_model.sv
// behavioural mac sending one four-nibble frame per request
`timescale 1ns/100ps
module pmd_mac_model (
  input wire logic clock,
  input wire logic rmii,
  input wire logic slow,
  input wire logic junk,
  input wire logic paceClk,
  input wire logic go,
  input wire logic [15:0] word,
  output logic txEnable,
  output logic [3:0] txData,
  output logic rmiiTxEnable,
  output logic [1:0] rmiiTxData,
  output logic busy
);
  logic [3:0] nib;
  logic [1:0] dib;
  int i;
  int r;
  // idle lines carry 00 unless a scenario asks for junk the port must ignore
  assign txData = txEnable ? nib : (junk ? 4'ha : 4'h0);
  assign rmiiTxData = rmiiTxEnable ? dib : (junk ? 2'h3 : 2'h0);
  // step just past the next rise of the pace clock, as a real mac would
  task automatic next_rise();
    logic prev;
    logic hit;
    hit = 1'b0;
    while (!hit) begin
      prev = paceClk;
      @(posedge clock);
      #1;
      hit = paceClk && !prev;
    end
  endtask
  // enable rises with the first unit and drops after the last one
  initial begin
    txEnable = 1'b0;
    rmiiTxEnable = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      for (i = 0; i < 8; i++) begin
        if (rmii) begin
          for (r = 0; r < (slow ? 10 : 1); r++) begin
            next_rise();
            rmiiTxEnable = 1'b1;
            dib = word[i*2+:2];
          end
        end else if (i < 4) begin
          next_rise();
          txEnable = 1'b1;
          nib = word[i*4+:4];
        end
      end
      next_rise();
      txEnable = 1'b0;
      rmiiTxEnable = 1'b0;
      busy = 1'b0;
    end
  end
endmodule // pmd_mac_model

// >>> pmd_phy_data_port_tb.sv
// self-checking bench for the phy data port
`timescale 1ns/100ps
module pmd_phy_data_port_tb;
  logic clock, rst_n, clockMode50, speed100, fullDuplex, linkUp, go, junk, busy, rmiiMode;
  logic txClockOut, txEnable, rxClockOut, rxClockRecovered, rxValid, rxError, carrierSense;
  logic collision, refClockOut, refClockOutEnable, rmiiTxEnable, crsDv, rmiiRxError;
  logic rxClkLast, refClkLast, rxErrSeen, colSeen;
  logic [2:0] modeStrap;
  logic [3:0] txData, rxData;
  logic [1:0] rmiiTxData, rmiiRxData;
  logic [15:0] word, txAcc, rxAcc;
  pmd_pkg::pmd_line_rx_t lineRx;
  pmd_pkg::pmd_line_tx_t lineTx;
  int num_errors, checks_done, cycles;
  pmd_phy_data_port i_pmd_phy_data_port (.clock(clock), .rst_n(rst_n), .modeStrap(modeStrap),
    .clockMode50(clockMode50), .speed100(speed100), .fullDuplex(fullDuplex), .linkUp(linkUp),
    .lineRx(lineRx), .lineTx(lineTx), .txClockOut(txClockOut), .txEnable(txEnable),
    .txData(txData), .rxClockOut(rxClockOut), .rxClockRecovered(rxClockRecovered),
    .rxValid(rxValid), .rxData(rxData), .rxError(rxError), .carrierSense(carrierSense),
    .collision(collision), .refClockOut(refClockOut), .refClockOutEnable(refClockOutEnable),
    .rmiiTxEnable(rmiiTxEnable), .rmiiTxData(rmiiTxData), .crsDv(crsDv),
    .rmiiRxData(rmiiRxData), .rmiiRxError(rmiiRxError));
  pmd_mac_model i_pmd_mac_model (.clock(clock), .rmii(rmiiMode), .slow(!speed100), .junk(junk),
    .paceClk(rmiiMode ? refClockOut : txClockOut), .go(go), .word(word), .txEnable(txEnable),
    .txData(txData), .rmiiTxEnable(rmiiTxEnable), .rmiiTxData(rmiiTxData), .busy(busy));
  always #25 clock = ~clock;
  // gather delivered units, newest in the top bits, plus sticky flags and a hang limit
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (lineTx.strobe === 1'b1) txAcc <= {lineTx.nibble, txAcc[15:4]};
    if (rxClockOut && !rxClkLast && rxValid) rxAcc <= {rxData, rxAcc[15:4]};
    if (refClockOut && !refClkLast && crsDv) rxAcc <= {rmiiRxData, rxAcc[15:2]};
    rxClkLast <= rxClockOut;
    refClkLast <= refClockOut;
    if (rxError || rmiiRxError) rxErrSeen <= 1'b1;
    if (collision) colSeen <= 1'b1;
    if (cycles > 20000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask
  // speed only moves under reset, where the straps are also taken
  task automatic do_reset(input logic [2:0] strap, input logic s100);
    rst_n = 1'b0;
    modeStrap = strap;
    speed100 = s100;
    rmiiMode = (strap == pmd_pkg::STRAP_RMII);
    step(4);
    rst_n = 1'b1;
  endtask
  // line up with a receive slot so the one-entry hold never overflows
  task automatic align();
    logic prev;
    for (int k = 0; k < 20; k++) begin
      prev = rmiiMode ? refClockOut : rxClockOut;
      step(1);
      if ((rmiiMode ? refClockOut : rxClockOut) && !prev) break;
    end
  endtask
  task automatic feed(input logic [3:0] n, input logic err, input logic sfd, input int gap);
    {lineRx.strobe, lineRx.nibble, lineRx.codeErr, lineRx.sfd} = {1'b1, n, err, sfd};
    step(1);
    {lineRx.strobe, lineRx.codeErr, lineRx.sfd} = 3'h0;
    step(gap - 1);
  endtask
  task automatic t_tx(input logic [2:0] strap, input logic s100, input logic [15:0] w);
    do_reset(strap, s100);
    modeStrap = strap ^ 3'h1;
    junk = 1'b1;
    txAcc = 16'h0;
    step(30);
    check_val(txAcc, 16'h0);
    word = w;
    go = 1'b1;
    step(1);
    go = 1'b0;
    for (int k = 0; k < 400 && busy; k++) step(1);
    step(3);
    check_val(txAcc, w);
    junk = 1'b0;
  endtask
  task automatic t_rx_mii100();
    do_reset(3'h0, 1'b1);
    fullDuplex = 1'b0;
    {rxErrSeen, colSeen, rxAcc, word, go} = {2'h0, 16'h0, 16'h1234, 1'b1};
    {lineRx.carrier, lineRx.startPair} = 2'h3;
    step(1);
    {lineRx.startPair, go} = 2'h0;
    step(1);
    check_val(carrierSense, 1'b1);
    align();
    feed(4'h5, 1'b0, 1'b0, 2);
    feed(4'h5, 1'b0, 1'b0, 2);
    feed(4'ha, 1'b1, 1'b0, 2);
    feed(4'h3, 1'b0, 1'b0, 2);
    feed(4'hc, 1'b0, 1'b0, 2);
    lineRx.endPair = 1'b1;
    step(1);
    {lineRx.endPair, lineRx.carrier} = 2'h0;
    step(1);
    check_val(carrierSense, 1'b0);
    for (int k = 0; k < 40 && rxValid; k++) step(1);
    check_val(rxAcc, 16'hc3a5);
    check_val(rxErrSeen, 1'b1);
    check_val(colSeen, 1'b1);
  endtask
  // preamble nibbles are withheld until the delimiter at the low rate
  task automatic t_rx_mii10();
    do_reset(3'h0, 1'b0);
    fullDuplex = 1'b1;
    rxAcc = 16'h0;
    {lineRx.carrier, lineRx.squelch} = 2'h3;
    step(1);
    lineRx.squelch = 1'b0;
    step(1);
    check_val(carrierSense, 1'b1);
    align();
    feed(4'h5, 1'b0, 1'b0, 8);
    feed(4'h5, 1'b0, 1'b0, 8);
    feed(4'hd, 1'b0, 1'b1, 8);
    feed(4'h7, 1'b0, 1'b0, 8);
    feed(4'he, 1'b0, 1'b0, 8);
    lineRx.eof = 1'b1;
    step(1);
    {lineRx.eof, lineRx.carrier} = 2'h0;
    step(1);
    check_val(carrierSense, 1'b0);
    for (int k = 0; k < 60 && rxValid; k++) step(1);
    check_val(rxAcc, 16'he7d0);
    linkUp = 1'b0;
    step(1);
    check_val(rxClockRecovered, 1'b0);
    linkUp = 1'b1;
  endtask
  task automatic t_rx_rmii();
    do_reset(3'h1, 1'b1);
    clockMode50 = 1'b1;
    step(1);
    check_val(refClockOutEnable, 1'b0);
    clockMode50 = 1'b0;
    step(1);
    check_val(refClockOutEnable, 1'b1);
    {rxAcc, rxErrSeen, lineRx.carrier, lineRx.twoZeros, lineRx.startPair} = {16'h0, 4'h7};
    step(1);
    {lineRx.twoZeros, lineRx.startPair} = 2'h0;
    check_val(crsDv, 1'b1);
    align();
    feed(4'h9, 1'b1, 1'b0, 4);
    feed(4'h6, 1'b0, 1'b0, 4);
    // frame ends with the end pair as carrier goes, so crs_dv can drop
    {lineRx.carrier, lineRx.endPair} = 2'h1;
    step(1);
    lineRx.endPair = 1'b0;
    for (int k = 0; k < 20 && crsDv; k++) step(1);
    check_val(rxAcc, 16'h6900);
    check_val(rxErrSeen, 1'b1);
  endtask
  initial begin
    {clock, rst_n, clockMode50, fullDuplex, linkUp, go, junk} = 7'h0d;
    {rxClkLast, refClkLast, rxErrSeen, colSeen, word, txAcc, rxAcc} = '0;
    {lineRx, num_errors, checks_done, cycles} = '0;
    t_tx(3'h0, 1'b1, 16'h5d21);
    t_tx(3'h0, 1'b0, 16'h8e4b);
    t_tx(3'h1, 1'b1, 16'h5d21);
    t_tx(3'h1, 1'b0, 16'hc3f0);
    t_rx_mii100();
    t_rx_mii10();
    t_rx_rmii();
    stop_test();
  end
endmodule // pmd_phy_data_port_tb
